// file: hdl/bts_pkg.sv
package bts_pkg;

  // Word and address geometry
  localparam int DATA_W = 18;
  localparam int ADDR_W = 18;
  localparam int ARRAY_DEPTH = 2 ** ADDR_W;
  localparam int LANES = 2;
  localparam int LANE_W = 9;

  // Positions inside the synchronised pin bundle
  localparam int SB_K = 0;
  localparam int SB_KN = 1;
  localparam int SB_C = 2;
  localparam int SB_CN = 3;
  localparam int SB_RSEL = 4;
  localparam int SB_WSEL = 5;
  localparam int SB_M0 = 6;
  localparam int SB_M1 = 7;
  localparam int SB_ADDR_LO = 8;
  localparam int SB_D_LO = SB_ADDR_LO + ADDR_W;
  localparam int SB_W = SB_D_LO + DATA_W;

  // Start-up sequencing after reset release
  localparam logic [1:0] STRAP_SAMPLE = 2'h2;
  localparam logic [1:0] STRAP_WAIT = 2'h3;
  localparam logic [1:0] STRAP_STEP = 2'h1;
  localparam logic [1:0] STRAP_RESET = 2'h0;

  // Reset and idle values
  localparam logic [DATA_W-1:0] DATA_ZERO = 18'h0_0000;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 18'h0_0000;
  localparam logic [LANES-1:0] MASK_NONE = 2'h3;

endpackage

// file: hdl/bts_sync.sv
`timescale 1ns/1ps
module bts_sync #(
  parameter int W = 1
) (
  input wire logic i_clk, // Sampling clock
  input wire logic i_resetn, // Synchronous reset, active low
  input wire logic [W-1:0] i_d, // Asynchronous pins
  output logic [W-1:0] o_q // Synchronised copy
);

  logic [W-1:0] meta_q;

  // Two flip-flops per bit; the first feeds only the second
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      meta_q <= '0;
      o_q <= '0;
    end else begin
      meta_q <= i_d;
      o_q <= meta_q;
    end
  end

endmodule

// file: hdl/bts_array.sv
`timescale 1ns/1ps
module bts_array (
  input wire logic i_clk, // Core clock
  input wire logic i_we, // Self-timed write pulse
  input wire logic [bts_pkg::ADDR_W-1:0] i_waddr, // Write location
  input wire logic [bts_pkg::DATA_W-1:0] i_wdata, // Write word
  input wire logic [bts_pkg::LANES-1:0] i_lane_n, // Lane masks, low writes
  input wire logic [bts_pkg::ADDR_W-1:0] i_raddr, // Read location
  output logic [bts_pkg::DATA_W-1:0] o_rdata // Read word
);

  // One flop store per 9-bit lane; masked lanes keep their contents
  for (genvar g = 0; g < bts_pkg::LANES; g++) begin : g_lane
    logic [bts_pkg::LANE_W-1:0] lane_q [bts_pkg::ARRAY_DEPTH];
    always_ff @(posedge i_clk) begin
      if (i_we && !i_lane_n[g]) begin
        lane_q[i_waddr] <= i_wdata[g*bts_pkg::LANE_W +: bts_pkg::LANE_W];
      end
    end
    assign o_rdata[g*bts_pkg::LANE_W +: bts_pkg::LANE_W] = lane_q[i_raddr];
  end

endmodule

// file: hdl/bts_sram_top.sv
`timescale 1ns/1ps
// Contract
// - Read address taken from shared bus at positive input clock rise on read start.
// - Write address taken from shared bus at negative input clock rise.
// - Accesses start only at a positive input clock rising edge.
// - Each location holds two 18-bit words; every access moves both.
// - Write data taken on both input phases; read data out on both output phases.
// - Single clock mode uses the input clock pair to time read data.
// - Low write select at positive rise starts a write; high ignores write data.
// - Write data sampled on both input phases only during a valid write.
// - Lane masks sampled with each word; bits 8..0 and 17..9; unselected lanes kept.
// - Storage is two arrays of 256K x 18, 512K x 18 total.
// - Address ignored at a capture edge of a deselected port.
// - Low read select at positive rise starts a two-word read; high deselects.
// - Deselected read port finishes pending read, then floats after next output rise.
// - Read data comes from registers clocked by the output clock pair.
// - Array write is self-timed, needing no strobes beyond clocked inputs.
// - Read and write ports never stall or alter each other.
// - Low word driven at output rise after next input rise; high word follows.
// - First write word at starting positive rise; second with address at negative rise.
// - Same-location read returns newest data, forwarding a write from previous rise.
// - At power-up both ports are deselected and read outputs float.
module bts_sram_top (
  input wire logic i_ref_clk, // Core clock, 25 MHz
  input wire logic i_resetn, // Synchronous reset, active low
  input wire logic i_kclk, // Positive input clock pin
  input wire logic i_kclk_n, // Negative input clock pin
  input wire logic i_cclk, // Positive output clock pin
  input wire logic i_cclk_n, // Negative output clock pin
  input wire logic [bts_pkg::ADDR_W-1:0] i_addr, // Shared address bus
  input wire logic [bts_pkg::DATA_W-1:0] i_wr_data, // Write data bus
  input wire logic i_fetch_select_n, // Read port select, active low
  input wire logic i_store_select_n, // Write port select, active low
  input wire logic i_lane0_mask_n, // Lane 0 write select, active low
  input wire logic i_lane1_mask_n, // Lane 1 write select, active low
  output logic [bts_pkg::DATA_W-1:0] o_rd_data, // Read data bus
  output logic o_rd_data_oe // Read data drive enable
);

  logic [bts_pkg::SB_W-1:0] pins;
  logic [bts_pkg::SB_W-1:0] sync_s;
  logic [1:0] strap_cnt_q;
  logic single_q;
  logic k_prev_q;
  logic kn_prev_q;
  logic c_prev_q;
  logic cn_prev_q;
  logic ready;
  logic k_s;
  logic kn_s;
  logic c_s;
  logic cn_s;
  logic rsel_n_s;
  logic wsel_n_s;
  logic [bts_pkg::LANES-1:0] mask_s;
  logic [bts_pkg::ADDR_W-1:0] addr_s;
  logic [bts_pkg::DATA_W-1:0] data_s;
  logic k_rise;
  logic kn_rise;
  logic o_rise;
  logic on_rise;

  // Bundle every pin for a common two-stage crossing
  assign pins = {i_wr_data, i_addr, i_lane1_mask_n, i_lane0_mask_n, i_store_select_n, i_fetch_select_n,
                 i_cclk_n, i_cclk, i_kclk_n, i_kclk};

  bts_sync #(
    .W(bts_pkg::SB_W)
  ) u_sync (
    .i_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_d(pins),
    .o_q(sync_s)
  );

  // Unpack synchronised pins
  assign k_s = sync_s[bts_pkg::SB_K];
  assign kn_s = sync_s[bts_pkg::SB_KN];
  assign c_s = sync_s[bts_pkg::SB_C];
  assign cn_s = sync_s[bts_pkg::SB_CN];
  assign rsel_n_s = sync_s[bts_pkg::SB_RSEL];
  assign wsel_n_s = sync_s[bts_pkg::SB_WSEL];
  assign mask_s = {sync_s[bts_pkg::SB_M1], sync_s[bts_pkg::SB_M0]};
  assign addr_s = sync_s[bts_pkg::SB_ADDR_LO +: bts_pkg::ADDR_W];
  assign data_s = sync_s[bts_pkg::SB_D_LO +: bts_pkg::DATA_W];

  // Hold off edges until the crossing carries real pin levels
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      strap_cnt_q <= bts_pkg::STRAP_RESET;
      single_q <= 1'b0;
    end else if (strap_cnt_q != bts_pkg::STRAP_WAIT) begin
      strap_cnt_q <= strap_cnt_q + bts_pkg::STRAP_STEP;
      if (strap_cnt_q == bts_pkg::STRAP_SAMPLE) begin
        single_q <= c_s & cn_s; // Strap: both output clocks high
      end
    end
  end

  assign ready = (strap_cnt_q == bts_pkg::STRAP_WAIT);

  // Previous clock levels for edge detection
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      k_prev_q <= 1'b0;
      kn_prev_q <= 1'b0;
      c_prev_q <= 1'b0;
      cn_prev_q <= 1'b0;
    end else begin
      k_prev_q <= k_s;
      kn_prev_q <= kn_s;
      c_prev_q <= c_s;
      cn_prev_q <= cn_s;
    end
  end

  // Rising edges only; output timing follows the input pair in single mode
  assign k_rise = ready & k_s & ~k_prev_q;
  assign kn_rise = ready & kn_s & ~kn_prev_q;
  assign o_rise = single_q ? k_rise : (ready & c_s & ~c_prev_q);
  assign on_rise = single_q ? kn_rise : (ready & cn_s & ~cn_prev_q);

  // Write port
  logic wr_start;
  logic wr_act_q;
  logic wcommit_q;
  logic [bts_pkg::ADDR_W-1:0] waddr_q;
  logic [bts_pkg::DATA_W-1:0] w0_q;
  logic [bts_pkg::DATA_W-1:0] w1_q;
  logic [bts_pkg::LANES-1:0] m0_q;
  logic [bts_pkg::LANES-1:0] m1_q;

  assign wr_start = k_rise & ~wsel_n_s;

  // Write sequencing: first word at positive rise, address and second word at negative rise
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      wr_act_q <= 1'b0;
    end else if (wr_start) begin
      wr_act_q <= 1'b1;
    end else if (k_rise || kn_rise) begin
      wr_act_q <= 1'b0;
    end
  end

  // Data and masks are taken only while a write is in flight
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      w0_q <= bts_pkg::DATA_ZERO;
      m0_q <= bts_pkg::MASK_NONE;
    end else if (wr_start) begin
      w0_q <= data_s;
      m0_q <= mask_s;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      waddr_q <= bts_pkg::ADDR_ZERO;
      w1_q <= bts_pkg::DATA_ZERO;
      m1_q <= bts_pkg::MASK_NONE;
      wcommit_q <= 1'b0;
    end else begin
      wcommit_q <= kn_rise & wr_act_q;
      if (kn_rise && wr_act_q) begin
        waddr_q <= addr_s;
        w1_q <= data_s;
        m1_q <= mask_s;
      end
    end
  end

  // Read port
  logic rd_pend_q;
  logic [bts_pkg::ADDR_W-1:0] raddr_q;
  logic [bts_pkg::DATA_W-1:0] rd0;
  logic [bts_pkg::DATA_W-1:0] rd1;
  logic [bts_pkg::DATA_W-1:0] f0;
  logic [bts_pkg::DATA_W-1:0] f1;
  logic fwd_hit;

  // Read start and address capture, independent of the write port
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      rd_pend_q <= 1'b0;
      raddr_q <= bts_pkg::ADDR_ZERO;
    end else if (k_rise) begin
      rd_pend_q <= ~rsel_n_s;
      if (!rsel_n_s) begin
        raddr_q <= addr_s;
      end
    end
  end

  // Two 256K x 18 arrays, one per burst word, sharing one location index
  bts_array u_array0 (
    .i_clk(i_ref_clk),
    .i_we(wcommit_q),
    .i_waddr(waddr_q),
    .i_wdata(w0_q),
    .i_lane_n(m0_q),
    .i_raddr(raddr_q),
    .o_rdata(rd0)
  );

  bts_array u_array1 (
    .i_clk(i_ref_clk),
    .i_we(wcommit_q),
    .i_waddr(waddr_q),
    .i_wdata(w1_q),
    .i_lane_n(m1_q),
    .i_raddr(raddr_q),
    .o_rdata(rd1)
  );

  // Forward lanes of a write committing in the same cycle as the fetch
  assign fwd_hit = wcommit_q & (waddr_q == raddr_q);
  for (genvar g = 0; g < bts_pkg::LANES; g++) begin : g_fwd
    assign f0[g*bts_pkg::LANE_W +: bts_pkg::LANE_W] = (fwd_hit & ~m0_q[g]) ?
        w0_q[g*bts_pkg::LANE_W +: bts_pkg::LANE_W] : rd0[g*bts_pkg::LANE_W +: bts_pkg::LANE_W];
    assign f1[g*bts_pkg::LANE_W +: bts_pkg::LANE_W] = (fwd_hit & ~m1_q[g]) ?
        w1_q[g*bts_pkg::LANE_W +: bts_pkg::LANE_W] : rd1[g*bts_pkg::LANE_W +: bts_pkg::LANE_W];
  end

  // Output pipeline
  logic arm_set;
  logic arm_q;
  logic arm_d;
  logic drive_now;
  logic second_q;
  logic [bts_pkg::DATA_W-1:0] arm_w0_q;
  logic [bts_pkg::DATA_W-1:0] arm_w1_q;
  logic [bts_pkg::DATA_W-1:0] hi_q;
  logic [bts_pkg::DATA_W-1:0] src0;
  logic [bts_pkg::DATA_W-1:0] src1;

  // Burst is armed at the input rise after the start and drained by output rises
  assign arm_set = k_rise & rd_pend_q;
  assign drive_now = o_rise & (arm_set | arm_q);
  assign src0 = arm_set ? f0 : arm_w0_q;
  assign src1 = arm_set ? f1 : arm_w1_q;
  assign arm_d = o_rise ? 1'b0 : (arm_set | arm_q);

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      arm_q <= 1'b0;
      arm_w0_q <= bts_pkg::DATA_ZERO;
      arm_w1_q <= bts_pkg::DATA_ZERO;
    end else begin
      arm_q <= arm_d;
      if (arm_set) begin
        arm_w0_q <= f0;
        arm_w1_q <= f1;
      end
    end
  end

  // Output registers: low word on positive rise, high word on negative rise, float when idle
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      o_rd_data <= bts_pkg::DATA_ZERO;
      o_rd_data_oe <= 1'b0;
      hi_q <= bts_pkg::DATA_ZERO;
      second_q <= 1'b0;
    end else if (drive_now) begin
      o_rd_data <= src0;
      hi_q <= src1;
      o_rd_data_oe <= 1'b1;
      second_q <= 1'b1;
    end else if (o_rise) begin
      o_rd_data_oe <= 1'b0;
      second_q <= 1'b0;
    end else if (on_rise && second_q) begin
      o_rd_data <= hi_q;
      second_q <= 1'b0;
    end
  end

  // Checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  sequence s_low_out;
    drive_now ##1 (o_rd_data_oe && second_q && o_rd_data == $past(src0));
  endsequence

  sequence s_high_out;
    (on_rise && second_q && !o_rise) ##1 (o_rd_data == $past(hi_q) && !second_q);
  endsequence

  a_rd_addr_capture:
    assert property (k_rise && !rsel_n_s |=> rd_pend_q && raddr_q == $past(addr_s))
      else $error("read address not captured at positive rise");

  a_wr_addr_capture:
    assert property (kn_rise && wr_act_q |=> wcommit_q && waddr_q == $past(addr_s))
      else $error("write address not captured at negative rise");

  a_start_on_k:
    assert property ($rose(wr_act_q) || $rose(rd_pend_q) |-> $past(k_rise))
      else $error("access started off a positive rise");

  a_wr_deselect:
    assert property (k_rise && wsel_n_s |=> !wr_act_q && $stable(w0_q))
      else $error("deselected write port took data");

  a_low_word:
    assert property (drive_now |-> s_low_out)
      else $error("low word not driven on output rise");

  a_high_word:
    assert property (on_rise && second_q && !o_rise |-> s_high_out)
      else $error("high word not driven on negative output rise");

  a_float_idle:
    assert property (o_rise && !arm_set && !arm_q |=> !o_rd_data_oe && !second_q)
      else $error("read outputs still driven after idle output rise");

  a_single_route:
    assert property (single_q |-> o_rise == k_rise && on_rise == kn_rise)
      else $error("single clock mode not using input pair");

  a_commit_once:
    assert property (wcommit_q |=> !wcommit_q)
      else $error("write commit lasted more than one cycle");

  a_power_up:
    assert property (!ready |-> !o_rd_data_oe && !wr_act_q && !rd_pend_q)
      else $error("port active before start-up done");

endmodule

// file: dv/bts_ctrl_model.sv
`timescale 1ns/1ps
module bts_ctrl_model (
  input wire logic i_ref_clk, // Design clock, paces the pins
  input wire logic [bts_pkg::DATA_W-1:0] i_rd_data, // Read bus
  input wire logic i_rd_data_oe, // Read bus enable
  output logic o_kclk, // Positive input clock
  output logic o_kclk_n, // Negative input clock
  output logic o_cclk, // Positive output clock
  output logic o_cclk_n, // Negative output clock
  output logic [bts_pkg::ADDR_W-1:0] o_addr, // Shared address bus
  output logic [bts_pkg::DATA_W-1:0] o_wr_data, // Write data
  output logic o_fetch_select_n, // Read port select
  output logic o_store_select_n, // Write port select
  output logic o_lane0_mask_n, // Lane 0 write select
  output logic o_lane1_mask_n // Lane 1 write select
);
  logic dual;

  // Output clocks held high from power-up pick single clock mode
  initial begin
    dual = 1'b0;
    o_kclk = 1'b0;
    o_kclk_n = 1'b1;
    o_cclk = 1'b1;
    o_cclk_n = 1'b1;
    o_addr = 18'h0_0000;
    o_wr_data = 18'h0_0000;
    o_fetch_select_n = 1'b1;
    o_store_select_n = 1'b1;
    o_lane0_mask_n = 1'b1;
    o_lane1_mask_n = 1'b1;
  end

  // Output clocks idle low and high; takes effect as dual clock mode at the next reset
  task automatic use_dual();
    dual = 1'b1;
    o_cclk = 1'b0;
    o_cclk_n = 1'b1;
  endtask

  // Wait some design clock edges, then step just past the edge
  task automatic step(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask

  // One input clock period of 8 design cycles; unused lines toggle so they carry no stale value
  task automatic frame(input logic rd_n, input logic wr_n, input logic [bts_pkg::ADDR_W-1:0] raddr,
                       input logic [bts_pkg::ADDR_W-1:0] waddr, input logic [bts_pkg::DATA_W-1:0] d0,
                       input logic [bts_pkg::DATA_W-1:0] d1, input logic [1:0] m0, input logic [1:0] m1,
                       output logic [bts_pkg::DATA_W-1:0] q3, output logic [bts_pkg::DATA_W-1:0] q7,
                       output logic oe3, output logic oe7);
    step(1);
    o_fetch_select_n = rd_n;
    o_store_select_n = wr_n;
    o_addr = rd_n ? ~o_addr : raddr;
    o_wr_data = wr_n ? ~o_wr_data : d0;
    {o_lane1_mask_n, o_lane0_mask_n} = m0;
    step(2);
    o_kclk = 1'b1;
    o_kclk_n = 1'b0;
    step(1);
    q3 = i_rd_data;
    oe3 = i_rd_data_oe;
    // In dual mode the output clocks trail the input pair by one design cycle
    if (dual) begin
      o_cclk = 1'b1;
      o_cclk_n = 1'b0;
    end
    step(1);
    o_addr = wr_n ? ~o_addr : waddr;
    o_wr_data = wr_n ? ~o_wr_data : d1;
    {o_lane1_mask_n, o_lane0_mask_n} = m1;
    step(2);
    o_kclk = 1'b0;
    o_kclk_n = 1'b1;
    step(1);
    q7 = i_rd_data;
    oe7 = i_rd_data_oe;
    if (dual) begin
      o_cclk = 1'b0;
      o_cclk_n = 1'b1;
    end
  endtask
endmodule

// file: dv/bts_sram_top_bench.sv
`timescale 1ns/1ps
module bts_sram_top_bench;
  logic i_ref_clk;
  logic i_resetn;
  logic kclk, kclk_n, cclk, cclk_n, fsel_n, ssel_n, m0_n, m1_n, rd_oe;
  logic [17:0] addr, wr_data, rd_data;
  int fails = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h0000_0036;
  logic [17:0] mem0 [int];
  logic [17:0] mem1 [int];
  logic [17:0] pool [4];
  logic rd_hist [2];
  logic [17:0] w0_hist [2];
  logic [17:0] w1_hist [2];

  bts_sram_top dut (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_kclk(kclk), .i_kclk_n(kclk_n),
    .i_cclk(cclk), .i_cclk_n(cclk_n), .i_addr(addr), .i_wr_data(wr_data), .i_fetch_select_n(fsel_n),
    .i_store_select_n(ssel_n), .i_lane0_mask_n(m0_n), .i_lane1_mask_n(m1_n), .o_rd_data(rd_data),
    .o_rd_data_oe(rd_oe));

  bts_ctrl_model u_ctrl (.i_ref_clk(i_ref_clk), .i_rd_data(rd_data), .i_rd_data_oe(rd_oe), .o_kclk(kclk),
    .o_kclk_n(kclk_n), .o_cclk(cclk), .o_cclk_n(cclk_n), .o_addr(addr), .o_wr_data(wr_data),
    .o_fetch_select_n(fsel_n), .o_store_select_n(ssel_n), .o_lane0_mask_n(m0_n), .o_lane1_mask_n(m1_n));

  // Design clock, 40 ns
  initial begin
    i_ref_clk = 1'b0;
    forever #20 i_ref_clk = ~i_ref_clk;
  end

  // Cut a hang short
  always @(posedge i_ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      fails++;
      end_of_test();
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [17:0] rnd18();
    logic [31:0] r;
    r = rnd();
    return r[17:0];
  endfunction

  // Lane merge: a high mask keeps the stored lane
  function automatic logic [17:0] mrg(input logic [17:0] old, input logic [17:0] nw, input logic [1:0] m);
    return {m[1] ? old[17:9] : nw[17:9], m[0] ? old[8:0] : nw[8:0]};
  endfunction

  task automatic check(input string what, input logic [17:0] exp, input logic [17:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One period on the pins, then compare with the reference memory
  task automatic run(input logic rd_n, input logic wr_n, input logic [17:0] ra, input logic [17:0] wa,
                     input logic [17:0] d0, input logic [17:0] d1, input logic [1:0] m0, input logic [1:0] m1);
    logic [17:0] q3, q7;
    logic oe3, oe7;
    u_ctrl.frame(rd_n, wr_n, ra, wa, d0, d1, m0, m1, q3, q7, oe3, oe7);
    check("enable at word1", 18'(rd_hist[1]), 18'(oe3));
    if (rd_hist[1]) check("word1", w1_hist[1], q3);
    check("enable at word0", 18'(rd_hist[0]), 18'(oe7));
    if (rd_hist[0]) check("word0", w0_hist[0], q7);
    if (!wr_n) begin
      mem0[wa] = mrg(mem0[wa], d0, m0);
      mem1[wa] = mrg(mem1[wa], d1, m1);
    end
    rd_hist[1] = rd_hist[0];
    w1_hist[1] = w1_hist[0];
    rd_hist[0] = !rd_n;
    w0_hist[0] = mem0[ra];
    w1_hist[0] = mem1[ra];
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Reset for two cycles, release just past an edge, wait out start-up, then the read bus must float
  task automatic do_reset();
    i_resetn = 1'b0;
    rd_hist = '{1'b0, 1'b0};
    repeat (2) @(posedge i_ref_clk);
    #1 i_resetn = 1'b1;
    repeat (8) @(posedge i_ref_clk);
    #1;
    check("enable after reset", 18'h0_0000, 18'(rd_oe));
  endtask

  // Random traffic with either port deselected now and then; idle periods let the last burst finish and float
  task automatic traffic(input int n);
    logic [31:0] r;
    for (int i = 0; i < n; i++) begin
      r = rnd();
      run(r[0], r[1], pool[r[3:2]], pool[r[5:4]], rnd18(), rnd18(), r[7:6], r[9:8]);
    end
    repeat (3) run(1'b1, 1'b1, 18'h0_0000, 18'h0_0000, 18'h0_0000, 18'h0_0000, 2'h3, 2'h3);
  endtask

  // Main sequence
  initial begin
    pool = '{18'h0_0000, 18'h3_FFFF, 18'h1_5555, 18'h2_AAAA};
    do_reset();
    // Fill the pool back to back, reading the location written one period before
    for (int i = 0; i < 4; i++) begin
      run(i == 0, 1'b0, pool[(i + 3) % 4], pool[i], rnd18(), rnd18(), 2'h0, 2'h0);
    end
    // Every mask pair on each word, read of the same location started alongside
    for (int m = 0; m < 16; m++) begin
      run(1'b0, 1'b0, pool[m % 4], pool[m % 4], rnd18(), rnd18(), m[1:0], m[3:2]);
    end
    traffic(40);
    // Second reset in mid-run: output clocks now trail the input pair by one cycle, giving dual clock mode
    u_ctrl.use_dual();
    do_reset();
    traffic(16);
    end_of_test();
  end
endmodule
